// ### shared/ufl_defs.svh
// address map, field positions, reset values and timing for the serial option block
`ifndef UFL_DEFS_SVH
`define UFL_DEFS_SVH

`define UFL_ADDR_OPT 16'h3082
`define UFL_ADDR_CTRL 16'h3088
`define UFL_ADDR_STAT 16'h3089
`define UFL_ADDR_DATA 16'h308A

`define UFL_OPT_RESET 8'h00
`define UFL_CTRL_RESET 8'h00
`define UFL_BYTE_ZERO 8'h00

`define UFL_CTRL_TX_ON 0
`define UFL_CTRL_RX_ON 1
`define UFL_CTRL_TX_DIR 2
`define UFL_CTRL_STANDBY 3
`define UFL_CTRL_TX_NINTH 4

`define UFL_ST_TX_BUSY 0
`define UFL_ST_RX_FULL 1
`define UFL_ST_IDLE 2
`define UFL_ST_PAR_ERR 3
`define UFL_ST_FRM_ERR 4
`define UFL_ST_STANDBY 5
`define UFL_ST_RX_NINTH 6
`define UFL_ST_RX_BUSY 7

`define UFL_IDLE_BITS_8 4'hA
`define UFL_IDLE_BITS_9 4'hB
`define UFL_LAST_BIT_8 4'h7
`define UFL_LAST_BIT_9 4'h8

`define UFL_CLK_PERIOD_NS 100
`define UFL_BIT_TIME_NS 8700
`define UFL_BIT_CYCLES (`UFL_BIT_TIME_NS / `UFL_CLK_PERIOD_NS)
`define UFL_BIT_END 8'(`UFL_BIT_CYCLES - 1)
`define UFL_HALF_END 8'(`UFL_BIT_CYCLES / 2 - 1)

`endif

// ### shared/ufl_pkg.sv
// types and shared helpers for the serial option block
package ufl_pkg;

  typedef struct packed {
    logic loopSelect;
    logic waitStop;
    logic receiverSourceSelect;
    logic nineBit;
    logic wakeAddressMark;
    logic idleType;
    logic parityEnable;
    logic parityType;
  } ufl_opt_t;

  typedef struct packed {
    logic [8:0] data;
    logic frameErr;
  } ufl_rx_char_t;

  typedef enum logic [1:0] {
    UFL_IDLE = 2'b00,
    UFL_START = 2'b01,
    UFL_DATA = 2'b11,
    UFL_STOP = 2'b10
  } ufl_line_state_t;

  // xor of the data bits below the most significant one
  function automatic logic ufl_low_parity(input logic [8:0] d, input logic nine);
    ufl_low_parity = nine ? ^d[7:0] : ^d[6:0];
  endfunction

  function automatic logic ufl_msb(input logic [8:0] d, input logic nine);
    ufl_msb = nine ? d[8] : d[7];
  endfunction

endpackage

// ### rtl/ufl_tx.sv
// serializer: start, 8 or 9 data bits lsb first, one stop bit
`timescale 1ns/1ps
`include "ufl_defs.svh"
module ufl_tx
  import ufl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic run,
  input wire logic nineBit,
  input wire logic start,
  input wire logic [8:0] txData,
  output logic txSerial,
  output logic txBusy
);

  ufl_line_state_t state;
  logic [7:0] cyc;
  logic [3:0] idx;
  logic [8:0] shift;
  logic cycEnd;

  assign cycEnd = (cyc == `UFL_BIT_END);
  assign txBusy = (state != UFL_IDLE);

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= UFL_IDLE;
      cyc <= 8'h00;
      idx <= 4'h0;
      shift <= 9'h000;
      txSerial <= 1'b1;
    end
    else if (run)
    begin
      cyc <= (state == UFL_IDLE || cycEnd) ? 8'h00 : cyc + 8'h01;
      case (state)
        UFL_IDLE:
        begin
          txSerial <= ~start;
          if (start)
          begin
            shift <= txData;
            state <= UFL_START;
          end
        end
        UFL_START:
        begin
          if (cycEnd)
          begin
            txSerial <= shift[0];
            idx <= 4'h0;
            state <= UFL_DATA;
          end
        end
        UFL_DATA:
        begin
          if (cycEnd)
          begin
            if (idx == (nineBit ? `UFL_LAST_BIT_9 : `UFL_LAST_BIT_8))
            begin
              txSerial <= 1'b1;
              state <= UFL_STOP;
            end
            else
            begin
              txSerial <= shift[1];
              shift <= {1'b0, shift[8:1]};
              idx <= idx + 4'h1;
            end
          end
        end
        UFL_STOP:
        begin
          if (cycEnd)
            state <= UFL_IDLE;
        end
        default:
          state <= UFL_IDLE;
      endcase
    end
  end

endmodule

// ### rtl/ufl_rx.sv
// deserializer sampling each bit at its middle
`timescale 1ns/1ps
`include "ufl_defs.svh"
module ufl_rx
  import ufl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic run,
  input wire logic nineBit,
  input wire logic serialIn,
  output logic rxDone,
  output ufl_rx_char_t rxChar,
  output logic rxBusy
);

  ufl_line_state_t state;
  logic [7:0] cyc;
  logic [3:0] idx;
  logic cycEnd;

  assign rxBusy = (state != UFL_IDLE);
  assign cycEnd = (cyc == (state == UFL_START ? `UFL_HALF_END : `UFL_BIT_END));

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= UFL_IDLE;
      cyc <= 8'h00;
      idx <= 4'h0;
      rxDone <= 1'b0;
      rxChar <= '0;
    end
    else
    begin
      rxDone <= 1'b0;
      if (run)
      begin
        cyc <= (state == UFL_IDLE || cycEnd) ? 8'h00 : cyc + 8'h01;
        case (state)
          UFL_IDLE:
          begin
            if (!serialIn)
              state <= UFL_START;
          end
          UFL_START:
          begin
            // a glitch shorter than half a bit is not a start
            if (cycEnd)
            begin
              idx <= 4'h0;
              rxChar.data <= 9'h000;
              state <= serialIn ? UFL_IDLE : UFL_DATA;
            end
          end
          UFL_DATA:
          begin
            if (cycEnd)
            begin
              rxChar.data[idx] <= serialIn;
              if (idx == (nineBit ? `UFL_LAST_BIT_9 : `UFL_LAST_BIT_8))
                state <= UFL_STOP;
              else
                idx <= idx + 4'h1;
            end
          end
          UFL_STOP:
          begin
            if (cycEnd)
            begin
              rxChar.frameErr <= ~serialIn;
              rxDone <= 1'b1;
              state <= UFL_IDLE;
            end
          end
          default:
            state <= UFL_IDLE;
        endcase
      end
    end
  end

endmodule

// ### rtl/ufl_top.sv
// serial option control: format, parity, wakeup, idle detect and loop routing
// Functional notes
// - the option register at 3082h is read and written by software.
// - loop select set routes transmitter output to the receiver and drops the receive pin.
// - wait-stop clear keeps the unit running in cpu wait, set freezes it.
// - receiver source select has no effect while loop select is clear.
// - loop select set with source select clear is internal loopback.
// - loop select and source select both set is single-wire on the transmit pin.
// - character length picks 8 data bits or 9 data bits, lsb first, framed by start and stop.
// - wakeup method picks idle-line wakeup or address-mark wakeup for standby.
// - idle type starts the idle count after the start bit or only after the stop bit.
// - idle is declared after 10 or 11 high bit times matching the character length.
// - parity enable generates and checks parity in the most significant data bit.
// - parity type picks even or odd, counting the parity bit itself.
// - address-mark wakes on msb set, idle-line wakes on an idle line.
// - in single-wire mode the transmit direction decides if the pin drives.
// - with loop select set the receive pin is released for general use.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "ufl_defs.svh"
module ufl_top
  import ufl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [7:0] rdata,
  input wire logic cpuWait,
  input wire logic rxPin,
  input wire logic txPinIn,
  output logic txPinOut,
  output logic txPinOe,
  output logic rxPinFree,
  output logic clocksRunning
);

  ufl_opt_t opt;
  logic [7:0] ctrl;
  logic [8:0] txHold;
  logic txPending;
  logic [8:0] rxHold;
  logic rxFull;
  logic idleFlag;
  logic parErr;
  logic frmErr;
  logic standby;
  logic run;
  logic txStart;
  logic txSerial;
  logic txBusy;
  logic rxIn;
  logic rxDone;
  logic rxBusy;
  ufl_rx_char_t rxChar;
  logic [7:0] bitCyc;
  logic bitTick;
  logic [3:0] idleCnt;
  logic idleArmed;
  logic idleSeen;
  logic [3:0] idleLimit;
  logic wrOpt;
  logic wrCtrl;
  logic wrStat;
  logic wrData;
  logic rdData;
  logic wakeMark;
  logic deliver;
  logic [8:0] txFrame;
  logic [7:0] statusByte;

  assign wrOpt = wrStrobe && (addr == `UFL_ADDR_OPT);
  assign wrCtrl = wrStrobe && (addr == `UFL_ADDR_CTRL);
  assign wrStat = wrStrobe && (addr == `UFL_ADDR_STAT);
  assign wrData = wrStrobe && (addr == `UFL_ADDR_DATA);
  assign rdData = rdStrobe && (addr == `UFL_ADDR_DATA);

  // freezing holds every state machine where it stands
  assign run = !(cpuWait && opt.waitStop);

  // option register
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      opt <= ufl_opt_t'(`UFL_OPT_RESET);
    else if (wrOpt)
      opt <= ufl_opt_t'(wdata);
  end

  // link control: enables, direction, standby, ninth transmit bit
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      ctrl <= `UFL_CTRL_RESET;
    else if (wrCtrl)
      ctrl <= wdata;
  end

  // standby: software sets it, a wakeup condition clears it
  assign idleSeen = idleArmed && bitTick && rxIn && (idleCnt + 4'h1 >= idleLimit);
  assign wakeMark = rxDone && ufl_msb(rxChar.data, opt.nineBit);

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      standby <= 1'b0;
    else if (wrCtrl && wdata[`UFL_CTRL_STANDBY])
      standby <= 1'b1;
    else if (standby && (opt.wakeAddressMark ? wakeMark : idleSeen))
      standby <= 1'b0;
  end

  // transmit holding word; the ninth bit comes from link control
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      txHold <= 9'h000;
      txPending <= 1'b0;
    end
    else if (wrData)
    begin
      txHold <= {ctrl[`UFL_CTRL_TX_NINTH], wdata};
      txPending <= 1'b1;
    end
    else if (txStart)
      txPending <= 1'b0;
  end

  assign txStart = run && txPending && !txBusy && ctrl[`UFL_CTRL_TX_ON];

  // parity replaces the msb of the outgoing character
  always_comb
  begin
    txFrame = txHold;
    if (opt.parityEnable)
    begin
      if (opt.nineBit)
        txFrame[8] = ufl_low_parity(txHold, 1'b1) ^ opt.parityType;
      else
        txFrame[7] = ufl_low_parity(txHold, 1'b0) ^ opt.parityType;
    end
  end

  ufl_tx u_tx (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .run(run),
    .nineBit(opt.nineBit),
    .start(txStart),
    .txData(txFrame),
    .txSerial(txSerial),
    .txBusy(txBusy)
  );

  // receiver source: pin, internal loop, or the shared transmit pin
  always_comb
  begin
    if (!opt.loopSelect)
      rxIn = rxPin;
    else if (opt.receiverSourceSelect)
      rxIn = txPinIn;
    else
      rxIn = txSerial;
  end

  ufl_rx u_rx (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .run(run && ctrl[`UFL_CTRL_RX_ON]),
    .nineBit(opt.nineBit),
    .serialIn(rxIn),
    .rxDone(rxDone),
    .rxChar(rxChar),
    .rxBusy(rxBusy)
  );

  // pin drivers and pin release, all registered
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      txPinOut <= 1'b1;
      txPinOe <= 1'b0;
      rxPinFree <= 1'b1;
      clocksRunning <= 1'b1;
    end
    else
    begin
      txPinOut <= txSerial;
      if (opt.loopSelect && opt.receiverSourceSelect)
        txPinOe <= ctrl[`UFL_CTRL_TX_ON] && ctrl[`UFL_CTRL_TX_DIR];
      else
        txPinOe <= ctrl[`UFL_CTRL_TX_ON] || txBusy;
      rxPinFree <= opt.loopSelect || !ctrl[`UFL_CTRL_RX_ON];
      clocksRunning <= run;
    end
  end

  // bit-time tick for the idle detector
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      bitCyc <= 8'h00;
    else if (run)
      bitCyc <= (bitCyc == `UFL_BIT_END) ? 8'h00 : bitCyc + 8'h01;
  end

  assign bitTick = run && (bitCyc == `UFL_BIT_END);
  assign idleLimit = opt.nineBit ? `UFL_IDLE_BITS_9 : `UFL_IDLE_BITS_8;

  // high bits inside a frame count only when idle type is clear
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      idleCnt <= 4'h0;
      idleArmed <= 1'b1;
    end
    else
    begin
      if (!rxIn || (opt.idleType && rxBusy))
        idleCnt <= 4'h0;
      else if (bitTick && idleCnt < idleLimit)
        idleCnt <= idleCnt + 4'h1;
      if (rxDone)
        idleArmed <= 1'b1;
      else if (idleSeen)
        idleArmed <= 1'b0;
    end
  end

  // standby hides characters, except the address mark that ends it
  assign deliver = rxDone && (!standby || (opt.wakeAddressMark && wakeMark));

  // receive flags: hardware set wins over software clear
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rxHold <= 9'h000;
      rxFull <= 1'b0;
      parErr <= 1'b0;
      frmErr <= 1'b0;
    end
    else
    begin
      if (deliver)
        rxHold <= rxChar.data;
      if (deliver)
        rxFull <= 1'b1;
      else if (rdData)
        rxFull <= 1'b0;
      if (deliver && opt.parityEnable
          && ((ufl_low_parity(rxChar.data, opt.nineBit)
               ^ ufl_msb(rxChar.data, opt.nineBit)) != opt.parityType))
        parErr <= 1'b1;
      else if (wrStat && wdata[`UFL_ST_PAR_ERR])
        parErr <= 1'b0;
      if (deliver && rxChar.frameErr)
        frmErr <= 1'b1;
      else if (wrStat && wdata[`UFL_ST_FRM_ERR])
        frmErr <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      idleFlag <= 1'b0;
    else if (idleSeen)
      idleFlag <= 1'b1;
    else if (wrStat && wdata[`UFL_ST_IDLE])
      idleFlag <= 1'b0;
  end

  always_comb
  begin
    statusByte = `UFL_BYTE_ZERO;
    statusByte[`UFL_ST_TX_BUSY] = txBusy || txPending;
    statusByte[`UFL_ST_RX_FULL] = rxFull;
    statusByte[`UFL_ST_IDLE] = idleFlag;
    statusByte[`UFL_ST_PAR_ERR] = parErr;
    statusByte[`UFL_ST_FRM_ERR] = frmErr;
    statusByte[`UFL_ST_STANDBY] = standby;
    statusByte[`UFL_ST_RX_NINTH] = rxHold[8];
    statusByte[`UFL_ST_RX_BUSY] = rxBusy;
  end

  // read data stand one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      rdata <= `UFL_BYTE_ZERO;
    else if (rdStrobe)
    begin
      case (addr)
        `UFL_ADDR_OPT: rdata <= opt;
        `UFL_ADDR_CTRL: rdata <= {ctrl[7:4], standby, ctrl[2:0]};
        `UFL_ADDR_STAT: rdata <= statusByte;
        `UFL_ADDR_DATA: rdata <= rxHold[7:0];
        default: rdata <= `UFL_BYTE_ZERO;
      endcase
    end
    else
      rdata <= `UFL_BYTE_ZERO;
  end

endmodule

// ### verif/ufl_top_assertions.sv
// port checker for the serial option block
`timescale 1ns/1ps
`include "ufl_defs.svh"
module ufl_checker
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic [7:0] rdata,
  input wire logic cpuWait,
  input wire logic txPinOut,
  input wire logic txPinOe,
  input wire logic rxPinFree,
  input wire logic clocksRunning
);
  localparam int BitCycles = `UFL_BIT_CYCLES;
  logic [7:0] optShadow;
  logic [7:0] ctrlShadow;
  int lowRun;
  int highRun;
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      optShadow <= `UFL_OPT_RESET;
      ctrlShadow <= `UFL_CTRL_RESET;
    end
    else if (wrStrobe && addr == `UFL_ADDR_OPT)
      optShadow <= wdata;
    else if (wrStrobe && addr == `UFL_ADDR_CTRL)
      ctrlShadow <= wdata;
  end
  // high run saturates so a long idle line cannot wrap
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      lowRun <= 0;
      highRun <= 0;
    end
    else
    begin
      lowRun <= txPinOut ? 0 : lowRun + 1;
      highRun <= !txPinOut ? 0 : (highRun < 5000 ? highRun + 1 : highRun);
    end
  end
  rdata_idle_a:
    assert property (!$past(rdStrobe) |-> rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  opt_readback_a:
    assert property (rdStrobe && addr == `UFL_ADDR_OPT |=> rdata == $past(optShadow))
    else $error("option register read back wrong");
  clk_freeze_a:
    assert property ((cpuWait && optShadow[6])[*2] |-> !clocksRunning)
    else $error("unit not frozen in wait");
  rx_release_a:
    assert property (optShadow[7] [*2] |-> rxPinFree)
    else $error("receive pin held in loop mode");
  single_oe_a:
    assert property ((optShadow[7] && optShadow[5] && !(ctrlShadow[0] && ctrlShadow[2]))[*2] |-> !txPinOe)
    else $error("shared pin driven while receiving");
  tx_oe_a:
    assert property ((!optShadow[7] && ctrlShadow[0])[*2] |-> txPinOe)
    else $error("transmit pin not driven with transmitter on");
  bit_width_a:
    assert property ($rose(txPinOut) |-> lowRun % BitCycles == 0)
    else $error("low run not a whole number of bit times");
  start_delay_a:
    assert property (wrStrobe && addr == `UFL_ADDR_DATA && ctrlShadow[0] && !optShadow[7] && clocksRunning
      && highRun > 1100 |-> ##[2:3] $fell(txPinOut))
    else $error("start bit late after data write");
endmodule
bind ufl_top ufl_checker ufl_checker_i (.clk_sys(clk_sys), .resetn(resetn), .addr(addr), .wdata(wdata),
  .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdata(rdata), .cpuWait(cpuWait), .txPinOut(txPinOut),
  .txPinOe(txPinOe), .rxPinFree(rxPinFree), .clocksRunning(clocksRunning));

// ### verif/ufl_remote.sv
// remote serial transceiver on the far end of the line
`timescale 1ns/1ps
`include "ufl_defs.svh"
module ufl_remote
(
  input wire logic clk_sys,
  input wire logic txLine,
  input wire logic nineBit,
  output logic rxLine,
  output logic [8:0] gotWord,
  output int gotCount
);
  localparam int BitCycles = `UFL_BIT_CYCLES;
  initial
    rxLine = 1'b1;
  // mid-bit sampling of what the block sends; one process owns the results
  initial
  begin
    gotWord = 9'h000;
    gotCount = 0;
    forever
    begin
      @(negedge txLine);
      gotWord = 9'h000;
      repeat (BitCycles / 2) @(posedge clk_sys);
      for (int i = 0; i < (nineBit ? 9 : 8); i++)
      begin
        repeat (BitCycles) @(posedge clk_sys);
        gotWord[i] = txLine;
      end
      repeat (BitCycles) @(posedge clk_sys);
      gotCount = gotCount + 1;
    end
  end
  // line is left high after the stop bit, as a pulled-up idle line
  task automatic send(input logic [8:0] w, input logic nine);
    logic [10:0] frame;
    frame = nine ? {1'b1, w, 1'b0} : {2'b11, w[7:0], 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++)
    begin
      @(posedge clk_sys);
      rxLine <= frame[i];
      repeat (BitCycles - 1) @(posedge clk_sys);
    end
  endtask
endmodule

// ### verif/tb_top.sv
// self-checking bench for the serial option block
`timescale 1ns/1ps
`include "ufl_defs.svh"
module tb_top;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wrStrobe = 1'b0;
  logic rdStrobe = 1'b0;
  logic cpuWait = 1'b0;
  logic rxBreak = 1'b0;
  logic nineBit = 1'b0;
  logic [7:0] rdata;
  logic txPinOut, txPinOe, rxPinFree, clocksRunning, remoteLine;
  logic [8:0] gotWord;
  int gotCount;
  int n_fail = 0;
  int num_checks = 0;
  wire logic rxPin = rxBreak ? 1'b0 : remoteLine;
  wire logic txPinIn = txPinOe ? txPinOut : remoteLine;
  ufl_top ufl_top_i (.clk_sys(clk_sys), .resetn(resetn), .addr(addr), .wdata(wdata), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdata(rdata), .cpuWait(cpuWait), .rxPin(rxPin), .txPinIn(txPinIn),
    .txPinOut(txPinOut), .txPinOe(txPinOe), .rxPinFree(rxPinFree), .clocksRunning(clocksRunning));
  ufl_remote ufl_remote_i (.clk_sys(clk_sys), .txLine(txPinOut), .nineBit(nineBit), .rxLine(remoteLine),
    .gotWord(gotWord), .gotCount(gotCount));
  always #50 clk_sys = ~clk_sys;
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wrStrobe <= 1'b1;
    @(posedge clk_sys);
    wrStrobe <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk_sys);
    rdStrobe <= 1'b0;
    // read answer still stands here, the edge only retires it
    @(posedge clk_sys);
    v = rdata;
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk({1'b0, v}, {1'b0, exp});
  endtask
  task automatic wait_frame(input int n0);
    for (int i = 0; i < 1200 && gotCount == n0; i++)
      @(posedge clk_sys);
    chk(9'(gotCount - n0), 9'h001);
  endtask
  task automatic t_regs();
    rdchk(`UFL_ADDR_OPT, `UFL_OPT_RESET);
    rdchk(`UFL_ADDR_CTRL, `UFL_CTRL_RESET);
    wr(`UFL_ADDR_OPT, 8'h5B);
    rdchk(`UFL_ADDR_OPT, 8'h5B);
    rdchk(16'h3090, `UFL_BYTE_ZERO);
    wr(`UFL_ADDR_OPT, 8'h00);
  endtask
  task automatic t_wait();
    wr(`UFL_ADDR_OPT, 8'h40);
    cpuWait <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 chk({8'h00, clocksRunning}, 9'h000);
    wr(`UFL_ADDR_OPT, 8'h00);
    repeat (3) @(posedge clk_sys);
    #1 chk({8'h00, clocksRunning}, 9'h001);
    @(posedge clk_sys);
    cpuWait <= 1'b0;
  endtask
  // even, odd, nine bits plain, nine bits odd with ninth bit overridden
  task automatic t_tx();
    logic [8:0] want [4] = '{9'h087, 9'h007, 9'h155, 9'h100};
    logic [7:0] opts [4] = '{8'h02, 8'h03, 8'h10, 8'h13};
    logic [7:0] dats [4] = '{8'h07, 8'h07, 8'h55, 8'h00};
    int n0;
    repeat (1200) @(posedge clk_sys);
    for (int k = 0; k < 4; k++)
    begin
      wr(`UFL_ADDR_OPT, opts[k]);
      wr(`UFL_ADDR_CTRL, {3'b000, opts[k] == 8'h10, 4'h1});
      nineBit = opts[k][4];
      n0 = gotCount;
      wr(`UFL_ADDR_DATA, dats[k]);
      wait_frame(n0);
      chk(gotWord, want[k]);
    end
  endtask
  task automatic t_rx();
    logic [7:0] v;
    wr(`UFL_ADDR_OPT, 8'h00);
    wr(`UFL_ADDR_CTRL, 8'h03);
    nineBit = 1'b0;
    ufl_remote_i.send(9'h0C3, 1'b0);
    repeat (60) @(posedge clk_sys);
    rdchk(`UFL_ADDR_DATA, 8'hC3);
    wr(`UFL_ADDR_OPT, 8'h02);
    ufl_remote_i.send(9'h007, 1'b0);
    repeat (60) @(posedge clk_sys);
    rd(`UFL_ADDR_STAT, v);
    chk({8'h00, v[`UFL_ST_PAR_ERR]}, 9'h001);
    rdchk(`UFL_ADDR_DATA, 8'h07);
  endtask
  // idle count from start bit or stop bit, then idle-line and address-mark wakeup
  task automatic t_idle();
    logic [7:0] v;
    repeat (1000) @(posedge clk_sys);
    for (int k = 0; k < 2; k++)
    begin
      wr(`UFL_ADDR_OPT, {5'h00, k[0], 2'b00});
      wr(`UFL_ADDR_STAT, 8'h04);
      ufl_remote_i.send(9'h0FF, 1'b0);
      repeat (200) @(posedge clk_sys);
      rd(`UFL_ADDR_STAT, v);
      chk({8'h00, v[`UFL_ST_IDLE]}, {8'h00, !k[0]});
      repeat (700) @(posedge clk_sys);
      rd(`UFL_ADDR_STAT, v);
      chk({8'h00, v[`UFL_ST_IDLE]}, 9'h001);
      rdchk(`UFL_ADDR_DATA, 8'hFF);
    end
    for (int k = 0; k < 2; k++)
    begin
      wr(`UFL_ADDR_OPT, {4'h0, k[0], 3'b000});
      wr(`UFL_ADDR_CTRL, 8'h0B);
      ufl_remote_i.send(9'h023, 1'b0);
      repeat (60) @(posedge clk_sys);
      rd(`UFL_ADDR_STAT, v);
      chk({7'h00, v[`UFL_ST_STANDBY], v[`UFL_ST_RX_FULL]}, 9'h002);
      if (k == 0)
        repeat (1000) @(posedge clk_sys);
      else
        ufl_remote_i.send(9'h0A5, 1'b0);
      repeat (60) @(posedge clk_sys);
      rd(`UFL_ADDR_STAT, v);
      chk({7'h00, v[`UFL_ST_STANDBY], v[`UFL_ST_RX_FULL]}, {8'h00, k[0]});
    end
    rdchk(`UFL_ADDR_DATA, 8'hA5);
  endtask
  // receive pin held low whenever the loop should ignore it
  task automatic t_loop();
    wr(`UFL_ADDR_OPT, 8'h80);
    rxBreak <= 1'b1;
    wr(`UFL_ADDR_DATA, 8'h3C);
    repeat (1000) @(posedge clk_sys);
    rdchk(`UFL_ADDR_DATA, 8'h3C);
    chk({8'h00, rxPinFree}, 9'h001);
    wr(`UFL_ADDR_OPT, 8'hA0);
    repeat (3) @(posedge clk_sys);
    #1 chk({8'h00, txPinOe}, 9'h000);
    ufl_remote_i.send(9'h05A, 1'b0);
    repeat (60) @(posedge clk_sys);
    rdchk(`UFL_ADDR_DATA, 8'h5A);
    wr(`UFL_ADDR_CTRL, 8'h07);
    repeat (2) @(posedge clk_sys);
    chk({8'h00, txPinOe}, 9'h001);
    rxBreak <= 1'b0;
    wr(`UFL_ADDR_OPT, 8'h20);
    ufl_remote_i.send(9'h096, 1'b0);
    repeat (60) @(posedge clk_sys);
    rdchk(`UFL_ADDR_DATA, 8'h96);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    t_regs();
    t_wait();
    t_tx();
    t_rx();
    t_idle();
    t_loop();
    print_verdict();
  end
  // about three times the expected run length
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    n_fail++;
    print_verdict();
  end
endmodule
